/* hdl/scc_top.sv */
// Stepper chopper control: sequencer, chopper, bridge drive and thermal recovery
`timescale 1ns/1ps

// What this block does
// - Bridge switches driven only with enable high; all off otherwise.
// - Enable high and reset low force initial position, step inputs ignored.
// - Reset low with enable low still returns sequencer to initial position.
// - Standby follows mode select inputs regardless of enable.
// - Initial: full step A +100 B -100; other modes A 100 B 0.
// - Positive current flows from output one to output two.
// - Threshold is Vref/3 over sense resistor; peak detection comparator.
// - Subclock is master clock /20, chopping frequency master clock /100.
// - One chopping period equals five subclock periods.
// - Fast decay in final two subclock periods; fixed 40 percent.
// - Level exceeded at sample point: skip charge bar brief sense charge.
// - Forward: charge HS1+LS2, slow both LS, fast HS2+LS1.
// - Reverse: charge HS2+LS1, slow both LS, fast HS1+LS2.
// - Dead time about 300 ns with switches off on every drive change.
// - Auto recovery resumes at charge start, one to two periods later.
// - Latch release is enable high, low for 0.3 ms, high again.
// - Latch released at enable rise only if overtemperature has cleared.
// - Shutdown acts as enable low; auto return keeps step position.
// - Return select low latches, high recovers automatically.
// - In standby thermal shutdown recovers automatically.
// - Mode inputs pick standby or resolution; change restarts at initial.
// - Step inputs ignored for about 200 us after standby release.
// - Fault output pulls low during thermal or overcurrent shutdown.
// - Position monitor pulls low at initial position, except in standby.
module scc_top
#(
	parameter int EN_LOW_CYCLES = scc_pkg::EN_LOW_CYC,
	parameter int STBY_CYCLES   = scc_pkg::STBY_CYC
)
(
	input  wire logic               core_clk,
	input  wire logic               reset,
	input  wire logic               enable_in,
	input  wire logic               reset_n_in,
	input  wire logic               step_in,
	input  wire logic               rotation_direction_select,
	input  wire logic               step_mode_select_bit_one,
	input  wire logic               step_mode_select_bit_two,
	input  wire logic               step_mode_select_bit_three,
	input  wire logic               thermal_return_auto,
	input  wire logic               overtemp_in,
	input  wire logic               overcurrent_shutdown,
	input  wire logic               phase_a_over_level,
	input  wire logic               phase_b_over_level,
	output scc_pkg::scc_bridge_s    bridge_a,
	output scc_pkg::scc_bridge_s    bridge_b,
	output logic                    bridge_off,
	output scc_pkg::scc_phase_s     target_a,
	output scc_pkg::scc_phase_s     target_b,
	output logic                    fault_out,
	output logic                    fault_oe_n,
	output logic                    initial_position_flag_output,
	output logic                    initial_position_flag_oe_n,
	output logic                    standby
);
	import scc_pkg::*;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	localparam int NSYNC = 10;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;
	logic [NSYNC-1:0] raw_in;
	assign raw_in = {enable_in, reset_n_in, step_in, rotation_direction_select,
		step_mode_select_bit_one, step_mode_select_bit_two, step_mode_select_bit_three,
		thermal_return_auto, overtemp_in, phase_a_over_level};

	logic b_over_s1_q;
	logic b_over_q;

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			sync1_q     <= '0;
			sync2_q     <= '0;
			b_over_s1_q <= 1'b0;
			b_over_q    <= 1'b0;
		end
		else
		begin
			sync1_q     <= raw_in;
			sync2_q     <= sync1_q;
			b_over_s1_q <= phase_b_over_level;
			b_over_q    <= b_over_s1_q;
		end
	end

	logic       en_s;
	logic       rst_n_s;
	logic       step_s;
	logic       dir_s;
	logic [2:0] mode_s;
	logic       auto_s;
	logic       hot_s;
	logic       a_over_s;
	assign {en_s, rst_n_s, step_s, dir_s, mode_s, auto_s, hot_s, a_over_s} = sync2_q;

	function automatic logic is_standby(input logic [2:0] m);
		return (m == MODE_STBY_LO) || (m == MODE_STBY_HI);
	endfunction

	// ------------------------------------------------------------
	// Timing: master clock, subclock, chopping period
	// ------------------------------------------------------------
	logic [7:0] mdiv_q, mdiv_d;
	logic [4:0] sdiv_q, sdiv_d;
	logic [2:0] sub_q, sub_d;
	logic       mclk_tick;
	logic       sub_tick;
	logic       chop_start;

	assign mclk_tick  = (mdiv_q == 8'(MCLK_DIV - 1));
	assign sub_tick   = mclk_tick && (sdiv_q == 5'(SUB_DIV - 1));
	assign chop_start = sub_tick && (sub_q == SUB_LAST);

	always_comb
	begin
		mdiv_d = mclk_tick ? 8'h00 : mdiv_q + 8'h01;
		sdiv_d = sdiv_q;
		sub_d  = sub_q;
		if (mclk_tick)
			sdiv_d = (sdiv_q == 5'(SUB_DIV - 1)) ? 5'h00 : sdiv_q + 5'h01;
		if (sub_tick)
			sub_d = (sub_q == SUB_LAST) ? 3'h0 : sub_q + 3'h1;
	end

	// ------------------------------------------------------------
	// Standby, mode change, sequencer
	// ------------------------------------------------------------
	logic [2:0]        mode_q, mode_d;
	logic [POS_W-1:0]  pos_q, pos_d;
	logic              step_prev_q, step_prev_d;
	logic [15:0]       quiet_q, quiet_d;
	logic              stby;
	logic              eff_en;
	logic [POS_W-1:0]  inc;

	assign stby = is_standby(mode_s);

	always_comb
	begin
		unique case (mode_q)
			MODE_FULL:    inc = 6'h10;
			MODE_HALF_A,
			MODE_HALF_B:  inc = 6'h08;
			MODE_QUARTER: inc = 6'h04;
			MODE_EIGHTH:  inc = 6'h02;
			default:      inc = 6'h01;
		endcase
		mode_d      = mode_s;
		step_prev_d = step_s;
		pos_d       = pos_q;
		quiet_d     = (quiet_q != 16'h0000) ? quiet_q - 16'h0001 : quiet_q;
		if (stby)
			quiet_d = 16'(STBY_CYCLES);
		if (mode_s != mode_q)
			pos_d = POS_INIT;
		else if (!rst_n_s)
			pos_d = POS_INIT;
		else if (eff_en && !stby && quiet_q == 16'h0000 && step_s && !step_prev_q)
			pos_d = dir_s ? pos_q - inc : pos_q + inc;
	end

	// Initial position of full step sits midway so A=+100, B=-100
	function automatic scc_phase_s phase_of(input logic [POS_W-1:0] p, input logic full,
		input logic cos_phase);
		logic [POS_W-1:0] q;
		logic [3:0]       r;
		scc_phase_s       ph;
		q  = cos_phase ? p : p - 6'h10;
		r  = q[3:0];
		ph.level    = q[4] ? 5'(r) : 5'h10 - 5'(r);
		if (full)
			ph.level = 5'h10;
		ph.negative = q[5] && (ph.level != 5'h00);
		return ph;
	endfunction

	// ------------------------------------------------------------
	// Thermal shutdown and enable sequence
	// ------------------------------------------------------------
	logic        tsd_q, tsd_d;
	logic        en_prev_q, en_prev_d;
	logic [19:0] low_cnt_q, low_cnt_d;
	logic        armed_q, armed_d;
	logic        wait_q, wait_d;
	logic [1:0]  cool_q, cool_d;

	always_comb
	begin
		tsd_d     = tsd_q;
		en_prev_d = en_s;
		wait_d    = wait_q;
		cool_d    = cool_q;
		armed_d   = armed_q;
		low_cnt_d = en_s ? 20'h00000 : low_cnt_q + ((low_cnt_q == 20'(EN_LOW_CYCLES)) ? 20'h0 : 20'h1);
		if (!en_s && low_cnt_q == 20'(EN_LOW_CYCLES))
			armed_d = 1'b1;
		if (en_s && !en_prev_q)
			armed_d = 1'b0;
		if (hot_s)
		begin
			tsd_d  = 1'b1;
			wait_d = 1'b0;
		end
		else if (tsd_q)
		begin
			if (auto_s || stby)
			begin
				if (!wait_q)
				begin
					wait_d = 1'b1;
					cool_d = 2'h0;
				end
				else if (chop_start)
				begin
					// Needs one full period before the release edge
					cool_d = cool_q + 2'h1;
					if (cool_q != 2'h0)
					begin
						tsd_d  = 1'b0;
						wait_d = 1'b0;
					end
				end
			end
			else if (en_s && !en_prev_q && armed_q)
				tsd_d = 1'b0;
		end
	end

	assign eff_en = en_s && !tsd_q;

	// ------------------------------------------------------------
	// Chopper state and bridge mapping
	// ------------------------------------------------------------
	scc_drive_e  drv_a_q, drv_a_d, drv_b_q, drv_b_d;
	logic        skip_a_q, skip_a_d, skip_b_q, skip_b_d;
	logic        run_q, run_d;
	logic [7:0]  dead_a_q, dead_a_d, dead_b_q, dead_b_d;
	scc_phase_s  ta, tb, ta_n, tb_n;

	// Next-cycle sign, so a current reversal also gets its dead time
	assign ta_n = phase_of(pos_d, mode_d == MODE_FULL, 1'b1);
	assign tb_n = phase_of(pos_d, mode_d == MODE_FULL, 1'b0);

	assign ta = phase_of(pos_q, mode_q == MODE_FULL, 1'b1);
	assign tb = phase_of(pos_q, mode_q == MODE_FULL, 1'b0);

	// Comparator compares peak current with Vref/3 over sense resistor
	function automatic scc_drive_e chop_next(input scc_drive_e cur, input logic over,
		input logic skip, input logic [2:0] sub, input logic tick);
		scc_drive_e n;
		n = cur;
		if (tick && sub == SUB_LAST)
			n = SCC_CHARGE;
		else if (tick && sub == MIXED_DECAY_SUB - 3'h1)
			n = SCC_FAST;
		else if (tick && skip && sub == SENSE_CHARGE_SUB && cur == SCC_CHARGE)
			n = SCC_SLOW;
		else if (cur == SCC_CHARGE && over && !skip)
			n = SCC_SLOW;
		return n;
	endfunction

	function automatic scc_bridge_s map_bridge(input scc_drive_e d, input logic neg);
		scc_bridge_s b;
		unique case (d)
			SCC_CHARGE: b = neg ? 4'b0110 : 4'b1001;
			SCC_FAST:   b = neg ? 4'b1001 : 4'b0110;
			default:    b = 4'b0011;
		endcase
		return b;
	endfunction

	always_comb
	begin
		run_d    = run_q;
		if (!en_s || tsd_d || stby)
			run_d = 1'b0;
		else if (chop_start)
			run_d = 1'b1;
		drv_a_d  = chop_next(drv_a_q, a_over_s, skip_a_q, sub_q, sub_tick);
		drv_b_d  = chop_next(drv_b_q, b_over_q, skip_b_q, sub_q, sub_tick);
		skip_a_d = skip_a_q;
		skip_b_d = skip_b_q;
		if (chop_start)
		begin
			skip_a_d = a_over_s;
			skip_b_d = b_over_q;
		end
		dead_a_d = (dead_a_q != 8'h00) ? dead_a_q - 8'h01 : 8'h00;
		dead_b_d = (dead_b_q != 8'h00) ? dead_b_q - 8'h01 : 8'h00;
		if (drv_a_d != drv_a_q || ta_n.negative != ta.negative)
			dead_a_d = 8'(DEAD_CYC);
		if (drv_b_d != drv_b_q || tb_n.negative != tb.negative)
			dead_b_d = 8'(DEAD_CYC);
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			mdiv_q <= 8'h00;  sdiv_q <= 5'h00;  sub_q <= 3'h0;
			mode_q <= MODE_STBY_LO;  pos_q <= POS_INIT;  step_prev_q <= 1'b0;
			quiet_q <= 16'h0000;  tsd_q <= 1'b0;  en_prev_q <= 1'b0;
			low_cnt_q <= 20'h00000;  armed_q <= 1'b0;  wait_q <= 1'b0;  cool_q <= 2'h0;
			drv_a_q <= SCC_CHARGE;  drv_b_q <= SCC_CHARGE;
			skip_a_q <= 1'b0;  skip_b_q <= 1'b0;  run_q <= 1'b0;
			dead_a_q <= 8'h00;  dead_b_q <= 8'h00;
		end
		else
		begin
			mdiv_q <= mdiv_d;  sdiv_q <= sdiv_d;  sub_q <= sub_d;
			mode_q <= mode_d;  pos_q <= pos_d;  step_prev_q <= step_prev_d;
			quiet_q <= quiet_d;  tsd_q <= tsd_d;  en_prev_q <= en_prev_d;
			low_cnt_q <= low_cnt_d;  armed_q <= armed_d;  wait_q <= wait_d;
			cool_q <= cool_d;  drv_a_q <= drv_a_d;  drv_b_q <= drv_b_d;
			skip_a_q <= skip_a_d;  skip_b_q <= skip_b_d;  run_q <= run_d;
			dead_a_q <= dead_a_d;  dead_b_q <= dead_b_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all registered
	// ------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			bridge_a   <= '0;
			bridge_b   <= '0;
			bridge_off <= 1'b1;
			target_a   <= '0;
			target_b   <= '0;
			fault_out  <= 1'b0;
			fault_oe_n <= 1'b1;
			initial_position_flag_output <= 1'b0;
			initial_position_flag_oe_n   <= 1'b1;
			standby    <= 1'b0;
		end
		else
		begin
			// Overlap during switch change would short the supply
			bridge_a   <= (run_q && dead_a_q == 8'h00) ? map_bridge(drv_a_q, ta.negative) : '0;
			bridge_b   <= (run_q && dead_b_q == 8'h00) ? map_bridge(drv_b_q, tb.negative) : '0;
			bridge_off <= !run_q;
			target_a   <= ta;
			target_b   <= tb;
			fault_out  <= 1'b0;
			fault_oe_n <= !(tsd_q || overcurrent_shutdown);
			initial_position_flag_output <= 1'b0;
			initial_position_flag_oe_n   <= stby || (pos_q != POS_INIT);
			standby    <= stby;
		end
	end

endmodule

/* pkg/scc_pkg.sv */
// Constants and types for the stepper chopper control block
package scc_pkg;

	// Step mode select codes {bit_one, bit_two, bit_three}
	localparam logic [2:0] MODE_STBY_LO = 3'h0;
	localparam logic [2:0] MODE_FULL    = 3'h1;
	localparam logic [2:0] MODE_HALF_A  = 3'h2;
	localparam logic [2:0] MODE_HALF_B  = 3'h3;
	localparam logic [2:0] MODE_QUARTER = 3'h4;
	localparam logic [2:0] MODE_EIGHTH  = 3'h5;
	localparam logic [2:0] MODE_SIXTEEN = 3'h6;
	localparam logic [2:0] MODE_STBY_HI = 3'h7;

	// Micro-step position: 64 positions per electrical cycle at 1/16
	localparam int          POS_W       = 6;
	localparam logic [5:0]  POS_INIT    = 6'h00;

	// Chopper timing
	localparam int          CLK_MHZ          = 250;
	localparam int          MCLK_KHZ         = 4000;
	localparam int          MCLK_DIV         = CLK_MHZ * 1000 / MCLK_KHZ;
	localparam int          SUB_DIV          = 20;
	localparam int          SUB_PER_CHOP     = 5;
	localparam logic [2:0]  SUB_LAST         = 3'h4;
	localparam logic [2:0]  MIXED_DECAY_SUB  = 3'h3;
	localparam logic [2:0]  SENSE_CHARGE_SUB = 3'h0;

	// Dead time, rounded up to whole cycles
	localparam int          DEAD_NS     = 300;
	localparam int          DEAD_CYC    = (DEAD_NS * CLK_MHZ + 999) / 1000;

	// Enable low time for latch release and standby exit quiet time
	localparam int          EN_LOW_US   = 300;
	localparam int          EN_LOW_CYC  = EN_LOW_US * CLK_MHZ;
	localparam int          STBY_US     = 200;
	localparam int          STBY_CYC    = STBY_US * CLK_MHZ;

	typedef enum logic [2:0]
	{
		SCC_CHARGE = 3'h1,
		SCC_SLOW   = 3'h2,
		SCC_FAST   = 3'h4
	} scc_drive_e;

	// Gate commands of one H-bridge
	typedef struct packed
	{
		logic high_side_one;
		logic high_side_two;
		logic low_side_one;
		logic low_side_two;
	} scc_bridge_s;

	// Phase target: sign and magnitude index (0..16 of full scale)
	typedef struct packed
	{
		logic       negative;
		logic [4:0] level;
	} scc_phase_s;

endpackage

/* testbench/scc_top_asserts.sv */
// Port-level assertions for the stepper chopper control block
`timescale 1ns/1ps
module scc_top_asserts
	import scc_pkg::*;
#(
	parameter int EN_LOW_CYCLES = 50,
	parameter int STBY_CYCLES   = 20
)
(
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic        enable_in,
	input wire logic        reset_n_in,
	input wire logic        step_mode_select_bit_one,
	input wire logic        step_mode_select_bit_two,
	input wire logic        step_mode_select_bit_three,
	input wire logic        overcurrent_shutdown,
	input scc_bridge_s      bridge_a,
	input scc_bridge_s      bridge_b,
	input logic             bridge_off,
	input scc_phase_s       target_a,
	input logic             fault_out,
	input logic             fault_oe_n,
	input logic             initial_position_flag_oe_n,
	input logic             standby
);
	logic [2:0] mode;

	assign mode = {step_mode_select_bit_one, step_mode_select_bit_two, step_mode_select_bit_three};

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	chk_off_when_low: assert property ((!enable_in) [*6] |-> bridge_off)
		else $error("bridges still active with enable low");
	chk_off_all_idle: assert property (bridge_off |-> bridge_a == '0 && bridge_b == '0)
		else $error("switch on while bridges are off");
	chk_no_shoot_thru: assert property (!(bridge_a.high_side_one && bridge_a.low_side_one)
		&& !(bridge_a.high_side_two && bridge_a.low_side_two)
		&& !(bridge_b.high_side_one && bridge_b.low_side_one)
		&& !(bridge_b.high_side_two && bridge_b.low_side_two))
		else $error("both switches of one leg on");
	chk_dead_entry: assert property (bridge_a != '0 && $changed(bridge_a) |-> $past(bridge_a) == '0)
		else $error("drive change without dead time");
	chk_dead_length: assert property ($fell(|bridge_a) |-> (bridge_a == '0) [*8])
		else $error("dead time too short");
	chk_fault_pull: assert property (overcurrent_shutdown |=> !fault_oe_n && !fault_out)
		else $error("fault output not pulled low");
	chk_standby_mode: assert property ((mode == MODE_STBY_LO || mode == MODE_STBY_HI) [*6] |-> standby && initial_position_flag_oe_n)
		else $error("standby not entered");
	chk_reset_home: assert property ((!reset_n_in && !standby) [*8] |-> !initial_position_flag_oe_n && target_a == 6'h10)
		else $error("reset did not return to initial position");
endmodule

/* testbench/scc_step_src.sv */
// Controller model issuing step pulses and rotation direction
`timescale 1ns/1ps
module scc_step_src
(
	input  wire logic core_clk,
	output logic      step_in,
	output logic      rotation_direction_select
);
	initial
	begin
		step_in = 1'b0;
		rotation_direction_select = 1'b0;
	end

	// Wide pulses so the synchronised edge is clean, 8 cycles high then 8 low
	task automatic pulse(input logic dir);
		@(negedge core_clk);
		rotation_direction_select = dir;
		repeat (4) @(negedge core_clk);
		step_in = 1'b1;
		repeat (8) @(negedge core_clk);
		step_in = 1'b0;
		repeat (8) @(negedge core_clk);
	endtask
endmodule

/* testbench/stepper_chopper_control_tb_top.sv */
// Self-checking bench for the stepper chopper control block
`timescale 1ns/1ps
module stepper_chopper_control_tb_top;
	import scc_pkg::*;
	localparam int EN_LOW = 50;
	localparam int STBY   = 20;
	localparam int CHOP   = MCLK_DIV * SUB_DIV * SUB_PER_CHOP;

	typedef struct packed
	{
		logic [2:0] mode;
		logic [5:0] exp_a;
		logic [5:0] exp_b;
		logic       exp_stby;
	} scc_row_s;

	logic        core_clk, reset, enable_in, reset_n_in, thermal_return_auto, overtemp_in;
	logic        overcurrent_shutdown, phase_a_over_level, phase_b_over_level;
	logic [2:0]  mode;
	logic        step_in, rotation_direction_select;
	scc_bridge_s bridge_a, bridge_b;
	scc_phase_s  target_a, target_b;
	logic        bridge_off, fault_out, fault_oe_n, flag_out, flag_oe_n, standby;
	int          n_errors = 0;
	int          checks = 0;
	scc_row_s    rows [8] = '{
		'{MODE_FULL, 6'h10, 6'h30, 1'b0}, '{MODE_HALF_A, 6'h10, 6'h00, 1'b0},
		'{MODE_HALF_B, 6'h10, 6'h00, 1'b0}, '{MODE_QUARTER, 6'h10, 6'h00, 1'b0},
		'{MODE_STBY_HI, 6'h00, 6'h00, 1'b1}, '{MODE_EIGHTH, 6'h10, 6'h00, 1'b0},
		'{MODE_STBY_LO, 6'h00, 6'h00, 1'b1}, '{MODE_SIXTEEN, 6'h10, 6'h00, 1'b0}};

	scc_top #(.EN_LOW_CYCLES(EN_LOW), .STBY_CYCLES(STBY)) i_dut (.core_clk(core_clk),
		.reset(reset), .enable_in(enable_in), .reset_n_in(reset_n_in), .step_in(step_in),
		.rotation_direction_select(rotation_direction_select),
		.step_mode_select_bit_one(mode[2]), .step_mode_select_bit_two(mode[1]),
		.step_mode_select_bit_three(mode[0]), .thermal_return_auto(thermal_return_auto),
		.overtemp_in(overtemp_in), .overcurrent_shutdown(overcurrent_shutdown),
		.phase_a_over_level(phase_a_over_level), .phase_b_over_level(phase_b_over_level),
		.bridge_a(bridge_a), .bridge_b(bridge_b), .bridge_off(bridge_off),
		.target_a(target_a), .target_b(target_b), .fault_out(fault_out),
		.fault_oe_n(fault_oe_n), .initial_position_flag_output(flag_out),
		.initial_position_flag_oe_n(flag_oe_n), .standby(standby));
	scc_step_src i_src (.core_clk(core_clk), .step_in(step_in),
		.rotation_direction_select(rotation_direction_select));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic wait_fault(input logic exp, input int limit);
		for (int i = 0; i < limit && fault_oe_n !== exp; i++)
			@(negedge core_clk);
	endtask

	task automatic wait_br(input logic [3:0] exp, input int limit);
		for (int i = 0; i < limit && bridge_a !== exp; i++)
			@(negedge core_clk);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	initial
	begin
		repeat (100000) @(posedge core_clk);
		n_errors++;
		wrap_up();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		{reset, enable_in, mode, thermal_return_auto, overtemp_in} = {2'h3, 3'h0, 2'h0};
		{reset_n_in, overcurrent_shutdown, phase_a_over_level, phase_b_over_level} = 4'h0;
		cyc(2);
		reset = 1'b0;
		cyc(4);
		chk({7'h0, bridge_off}, 8'h01);
		chk({7'h0, standby}, 8'h01);
		$display("test reset done");
		foreach (rows[i])
		begin
			mode = rows[i].mode;
			cyc(STBY + 30);
			chk({7'h0, standby}, {7'h0, rows[i].exp_stby});
			chk({7'h0, flag_oe_n}, {7'h0, rows[i].exp_stby});
			if (!rows[i].exp_stby)
			begin
				chk({2'h0, target_a}, {2'h0, rows[i].exp_a});
				chk({2'h0, target_b}, {2'h0, rows[i].exp_b});
			end
		end
		$display("test modes done");
		reset_n_in = 1'b1;
		cyc(10);
		i_src.pulse(1'b0);
		chk({7'h0, flag_oe_n}, 8'h01);
		i_src.pulse(1'b1);
		chk({7'h0, flag_oe_n}, 8'h00);
		i_src.pulse(1'b1);
		mode = MODE_EIGHTH;
		cyc(10);
		chk({7'h0, flag_oe_n}, 8'h00);
		chk({7'h0, flag_out}, 8'h00);
		mode = MODE_STBY_LO;
		cyc(10);
		mode = MODE_SIXTEEN;
		i_src.pulse(1'b0);
		chk({7'h0, flag_oe_n}, 8'h00);
		enable_in = 1'b0;
		i_src.pulse(1'b0);
		chk({7'h0, flag_oe_n}, 8'h00);
		enable_in = 1'b1;
		$display("test stepping done");
		wait_br(4'h9, 2 * CHOP);
		chk({4'h0, bridge_a}, 8'h09);
		chk({4'h0, bridge_b}, 8'h09);
		phase_a_over_level = 1'b1;
		wait_br(4'h3, 2 * CHOP);
		chk({4'h0, bridge_a}, 8'h03);
		wait_br(4'h6, CHOP);
		chk({4'h0, bridge_a}, 8'h06);
		phase_a_over_level = 1'b0;
		$display("test chopper done");
		for (int k = 0; k < 2; k++)
		begin
			thermal_return_auto = (k == 0);
			mode = (k == 0) ? MODE_SIXTEEN : MODE_STBY_HI;
			overtemp_in = 1'b1;
			wait_fault(1'b0, 20);
			chk({7'h0, fault_oe_n}, 8'h00);
			cyc(10);
			chk({7'h0, bridge_off}, 8'h01);
			overtemp_in = 1'b0;
			cyc(20);
			chk({7'h0, fault_oe_n}, 8'h00);
			wait_fault(1'b1, 2 * CHOP + 200);
			chk({7'h0, fault_oe_n}, 8'h01);
		end
		mode = MODE_SIXTEEN;
		thermal_return_auto = 1'b0;
		overtemp_in = 1'b1;
		wait_fault(1'b0, 20);
		enable_in = 1'b0;
		cyc(EN_LOW + 10);
		enable_in = 1'b1;
		cyc(20);
		chk({7'h0, fault_oe_n}, 8'h00);
		overtemp_in = 1'b0;
		cyc(2 * CHOP + 200);
		chk({7'h0, fault_oe_n}, 8'h00);
		enable_in = 1'b0;
		cyc(EN_LOW / 2);
		enable_in = 1'b1;
		cyc(20);
		chk({7'h0, fault_oe_n}, 8'h00);
		enable_in = 1'b0;
		cyc(EN_LOW + 10);
		enable_in = 1'b1;
		wait_fault(1'b1, 50);
		chk({7'h0, fault_oe_n}, 8'h01);
		overcurrent_shutdown = 1'b1;
		cyc(3);
		chk({6'h0, fault_oe_n, fault_out}, 8'h00);
		overcurrent_shutdown = 1'b0;
		$display("test thermal done");
		wrap_up();
	end
endmodule

bind scc_top scc_top_asserts #(.EN_LOW_CYCLES(EN_LOW_CYCLES), .STBY_CYCLES(STBY_CYCLES)) i_chk (.*);
